// ==== logic/ssb_pkg.sv ====
// Shared constants, types and timing for the burst-of-two SRAM link.
// Summary of operation
// R01: Loop-disable low bypasses the delay loop, debug only.
// R02: Bypass mode gives read latency of 1.5 cycles.
// R03: Controller waits 1024 clock cycles for loop lock.
// R04: Controller keeps idle cycles during loop lock.
// R05: Static input clock resets the delay loop.
// R06: Address and requests captured on true rising edge.
// R07: Write data and selects captured on both edges.
// R08: Low read request reads; both high is idle.
// R09: Read returns address word, then address plus one.
// R10: Outputs float 2.5 cycles after last read.
// R11: Read hitting in-progress write returns new data.
// R12: Output clocks tied high select input clock timing.
// R13: Read and write sequencers run independently.
// R14: Bursts start on true input clock; second beats on inverted input clock.
// R15: Burst words follow true then inverted output edges, inverted then true in bypass.
`default_nettype none
package ssb_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int SEL_W  = 2;
	localparam int LANE_W = DATA_W / SEL_W;
	localparam int MEM_WORDS = 256;
	localparam int FIFO_DEPTH = 32;
	localparam int CMD_W = 1 + ADDR_W + 2 * DATA_W + 2 * SEL_W;
	localparam int CLK_NS = 100;
	localparam int STATIC_NS = 30;
	localparam int STATIC_CYC = (STATIC_NS + CLK_NS - 1) / CLK_NS;
	localparam int K_HALF_CYC = 4;
	localparam logic [3:0] STATIC_LIMIT = 4'(STATIC_CYC + K_HALF_CYC);
	localparam logic [2:0] K_HALF_LAST = 3'(K_HALF_CYC - 1);
	localparam logic [10:0] LOCK_LAST = 11'h3ff;
	localparam logic [1:0] LAT_NORM_IDX = 2'h1;
	localparam logic [1:0] LAT_BYP_IDX = 2'h2;
	localparam int LAT_BYP_HALF = 3;
	localparam logic [2:0] HIZ_HALF = 3'h5;
	localparam logic [2:0] HOST_SKEW = 3'h1;
	localparam int MARK_W = 6;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;

	typedef enum logic [1:0] {
		DLL_LOCKING = 2'b00,
		DLL_LOCKED  = 2'b01,
		DLL_BYPASS  = 2'b11
	} ssb_dll_t;

	typedef enum logic {
		SEQ_IDLE   = 1'b0,
		SEQ_SECOND = 1'b1
	} ssb_seq_t;

	typedef enum logic {
		HS_WAIT = 1'b0,
		HS_RUN  = 1'b1
	} ssb_host_t;
endpackage
`default_nettype wire

// ==== logic/ssb_if.sv ====
// Pin bundle between the memory controller and the SRAM.
`default_nettype none
interface ssb_if;
	import ssb_pkg::*;
	logic              k;
	logic              kInv;
	logic              cClk;
	logic              cClkInv;
	logic              dllOff_n;
	logic              rdReq_n;
	logic              wrReq_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wrData;
	logic [SEL_W-1:0]  byteWriteSelect_n;
	logic [DATA_W-1:0] q;
	logic              qOe_n;
	logic              echoStrobe;
	logic              echoStrobeInv;

	modport device (
		input  k, kInv, cClk, cClkInv, dllOff_n, rdReq_n, wrReq_n, addr, wrData,
		input  byteWriteSelect_n,
		output q, qOe_n, echoStrobe, echoStrobeInv
	);
	modport host (
		output k, kInv, cClk, cClkInv, dllOff_n, rdReq_n, wrReq_n, addr, wrData,
		output byteWriteSelect_n,
		input  q, qOe_n, echoStrobe, echoStrobeInv
	);
endinterface
`default_nettype wire

// ==== logic/ssb_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
`default_nettype none
module ssb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys,  // System clock.
	input  wire logic             rst_n,    // Asynchronous reset, active low.
	input  wire logic             inValid,  // Write side offers a word.
	output logic                  inReady,  // FIFO has room.
	input  wire logic [WIDTH-1:0] inData,   // Word written.
	output logic                  outValid, // FIFO holds a word.
	input  wire logic             outReady, // Read side takes the word.
	output logic      [WIDTH-1:0] outData   // Oldest word.
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wrPtr;
	logic [PTR_W-1:0] rdPtr;
	logic [PTR_W:0]   fill;
	logic             push;
	logic             pop;

	assign inReady = fill != (PTR_W + 1)'(DEPTH);
	assign outValid = fill != '0;
	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outData = store[rdPtr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			store[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			fill <= '0;
		end else begin
			if (push) begin
				wrPtr <= PTR_W'(wrPtr + 1'b1);
			end
			if (pop) begin
				rdPtr <= PTR_W'(rdPtr + 1'b1);
			end
			if (push && !pop) begin
				fill <= fill + 1'b1;
			end else if (pop && !push) begin
				fill <= fill - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== logic/ssb_device.sv ====
// Memory end of the burst-of-two link: loop lock, read and write sequencing.
`default_nettype none
module ssb_device
	import ssb_pkg::*;
(
	input  wire logic clk_sys,    // System clock.
	input  wire logic rst_n,      // Asynchronous reset, active low.
	ssb_if.device     link,       // Pins facing the controller.
	output logic      dllLocked,  // Delay loop is locked.
	output logic      bypassMode  // Delay loop is bypassed.
);
	localparam int IN_W = 7 + ADDR_W + DATA_W + SEL_W;

	logic [IN_W-1:0]   syncA;
	logic [IN_W-1:0]   syncB;
	logic              kS;
	logic              kInvS;
	logic              cS;
	logic              cInvS;
	logic              loopOnS;
	logic              rdS_n;
	logic              wrS_n;
	logic [ADDR_W-1:0] addrS;
	logic [DATA_W-1:0] dataS;
	logic [SEL_W-1:0]  selS_n;
	logic [3:0]        clkPrev;
	logic              kRise;
	logic              kInvRise;
	logic              cRise;
	logic              cInvRise;
	logic              outOnK;
	logic              refTrue;
	logic              refEdge;
	logic [3:0]        staticCnt;
	logic              kStatic;
	ssb_dll_t          dllState;
	logic [10:0]       lockCnt;
	logic [DATA_W-1:0] mem [MEM_WORDS];
	ssb_seq_t          wrState;
	logic              wrTake;
	logic              wrCommit;
	logic [ADDR_W-1:0] wrAddr;
	logic [DATA_W-1:0] wrWord0;
	logic [SEL_W-1:0]  wrSel0_n;
	ssb_seq_t          rdState;
	logic              rdTake;
	logic              rdSecond;
	logic [ADDR_W-1:0] rdAddr1;
	logic              rdFwd;
	logic [DATA_W-1:0] word0;
	logic [DATA_W-1:0] word1;
	logic              loadV;
	logic [DATA_W-1:0] loadD;
	logic [LAT_BYP_HALF-1:0] pipeV;
	logic [DATA_W-1:0] pipeD [LAT_BYP_HALF];
	logic [1:0]        latIdx;
	logic              outV;
	logic [2:0]        hizCnt;
	logic [DATA_W-1:0] qReg;
	logic              qOeReg_n;
	logic              echoReg;

	// Overlays enabled byte lanes of a new word onto an old one.
	function automatic logic [DATA_W-1:0] ssb_merge(
		input logic [DATA_W-1:0] oldW,
		input logic [DATA_W-1:0] newW,
		input logic [SEL_W-1:0]  sel_n
	);
		logic [DATA_W-1:0] res;
		res = oldW;
		for (int i = 0; i < SEL_W; i++) begin
			if (!sel_n[i]) begin
				res[i*LANE_W +: LANE_W] = newW[i*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// Pin synchronisers and clock edge finders
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= '1;
			syncB <= '1;
		end else begin
			syncA <= {link.k, link.kInv, link.cClk, link.cClkInv, link.dllOff_n,
				link.rdReq_n, link.wrReq_n, link.addr, link.wrData, link.byteWriteSelect_n};
			syncB <= syncA;
		end
	end

	assign {kS, kInvS, cS, cInvS, loopOnS, rdS_n, wrS_n, addrS, dataS, selS_n} = syncB;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clkPrev <= 4'hf;
		end else begin
			clkPrev <= {kS, kInvS, cS, cInvS};
		end
	end

	assign kRise = kS & ~clkPrev[3]; // R14
	assign kInvRise = kInvS & ~clkPrev[2]; // R07
	assign cRise = cS & ~clkPrev[1];
	assign cInvRise = cInvS & ~clkPrev[0];
	assign outOnK = cS & cInvS; // R12
	assign refTrue = outOnK ? kRise : cRise; // R12
	assign refEdge = refTrue | (outOnK ? kInvRise : cInvRise); // R15

	// ----------------------------------------
	// Delay loop lock, static clock and bypass
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			staticCnt <= '0;
		end else if (kS != clkPrev[3]) begin
			staticCnt <= '0;
		end else if (staticCnt != STATIC_LIMIT) begin
			staticCnt <= staticCnt + 4'h1; // R05
		end
	end

	assign kStatic = staticCnt == STATIC_LIMIT; // R05

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dllState <= DLL_LOCKING;
		end else begin
			case (dllState)
				DLL_LOCKING: begin
					if (!loopOnS) begin
						dllState <= DLL_BYPASS; // R01
					end else if (kRise && lockCnt == LOCK_LAST) begin
						dllState <= DLL_LOCKED;
					end
				end
				DLL_LOCKED: begin
					if (!loopOnS) begin
						dllState <= DLL_BYPASS; // R01
					end else if (kStatic) begin
						dllState <= DLL_LOCKING; // R05
					end
				end
				DLL_BYPASS: begin
					if (loopOnS) begin
						dllState <= DLL_LOCKING;
					end
				end
				default: begin
					dllState <= DLL_LOCKING;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lockCnt <= '0;
		end else if (dllState != DLL_LOCKING || kStatic) begin
			lockCnt <= '0; // R05
		end else if (kRise) begin
			lockCnt <= lockCnt + 11'h001;
		end
	end

	assign dllLocked = dllState == DLL_LOCKED;
	assign bypassMode = dllState == DLL_BYPASS;

	// ----------------------------------------
	// Write sequencer and array
	// ----------------------------------------
	assign wrTake = kRise & ~wrS_n; // R06
	assign wrCommit = (wrState == SEQ_SECOND) & kInvRise; // R07

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrState <= SEQ_IDLE;
			wrAddr <= '0;
			wrWord0 <= '0;
			wrSel0_n <= '1;
		end else begin
			case (wrState)
				SEQ_IDLE: begin
					if (wrTake) begin
						wrState <= SEQ_SECOND; // R13
						wrAddr <= addrS;
						wrWord0 <= dataS; // R07
						wrSel0_n <= selS_n;
					end
				end
				SEQ_SECOND: begin
					if (kInvRise) begin
						wrState <= SEQ_IDLE;
					end
				end
				default: begin
					wrState <= SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (wrCommit) begin
			mem[wrAddr] <= ssb_merge(mem[wrAddr], wrWord0, wrSel0_n);
			mem[wrAddr + ADDR_STEP] <= ssb_merge(mem[wrAddr + ADDR_STEP], dataS, selS_n);
		end
	end

	// ----------------------------------------
	// Read sequencer with write forwarding
	// ----------------------------------------
	assign rdTake = kRise & ~rdS_n; // R08
	assign rdSecond = (rdState == SEQ_SECOND) & kInvRise;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdState <= SEQ_IDLE;
			rdAddr1 <= '0;
			rdFwd <= 1'b0;
		end else begin
			case (rdState)
				SEQ_IDLE: begin
					if (rdTake) begin
						rdState <= SEQ_SECOND; // R13
						rdAddr1 <= addrS + ADDR_STEP; // R09
						rdFwd <= wrTake; // R11
					end
				end
				SEQ_SECOND: begin
					if (kInvRise) begin
						rdState <= SEQ_IDLE;
					end
				end
				default: begin
					rdState <= SEQ_IDLE;
				end
			endcase
		end
	end

	assign word0 = wrTake ? ssb_merge(mem[addrS], dataS, selS_n) : mem[addrS]; // R11
	assign word1 = rdFwd ? ssb_merge(mem[rdAddr1], dataS, selS_n) : mem[rdAddr1]; // R11
	assign loadV = rdTake | rdSecond;
	assign loadD = rdTake ? word0 : word1; // R09

	// ----------------------------------------
	// Output pipeline, echo clocks and float
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pipeV <= '0;
		end else if (refEdge) begin
			pipeV <= {pipeV[LAT_BYP_HALF-2:0], loadV};
		end else if (loadV) begin
			pipeV[0] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (refEdge || loadV) begin
			pipeD[0] <= loadD;
		end
		if (refEdge) begin
			for (int i = 1; i < LAT_BYP_HALF; i++) begin
				pipeD[i] <= pipeD[i-1];
			end
		end
	end

	assign latIdx = bypassMode ? LAT_BYP_IDX : LAT_NORM_IDX; // R02
	assign outV = pipeV[latIdx];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			qReg <= '0;
			echoReg <= 1'b0;
		end else if (refEdge) begin
			echoReg <= refTrue; // R15
			if (outV) begin
				qReg <= pipeD[latIdx]; // R15
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hizCnt <= '0;
		end else if (rdTake) begin
			hizCnt <= HIZ_HALF; // R10
		end else if (refEdge && hizCnt != '0) begin
			hizCnt <= hizCnt - 3'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			qOeReg_n <= 1'b1;
		end else if (refEdge) begin
			if (hizCnt == 3'h1 && !rdTake) begin
				qOeReg_n <= 1'b1; // R10
			end else if (outV) begin
				qOeReg_n <= 1'b0;
			end
		end
	end

	assign link.q = qReg;
	assign link.qOe_n = qOeReg_n;
	assign link.echoStrobe = echoReg;
	assign link.echoStrobeInv = ~echoReg;
endmodule
`default_nettype wire

// ==== logic/ssb_host.sv ====
// Controller end of the burst-of-two link: clock maker, command issue, read capture.
`default_nettype none
module ssb_host
	import ssb_pkg::*;
(
	input  wire logic              clk_sys,    // System clock.
	input  wire logic              rst_n,      // Asynchronous reset, active low.
	ssb_if.host                    link,       // Pins facing the SRAM.
	input  wire logic              cmdValid,   // Command offered.
	output logic                   cmdReady,   // Command queue has room.
	input  wire logic              cmdWrite,   // One for write, zero for read.
	input  wire logic [ADDR_W-1:0] cmdAddr,    // Burst start address.
	input  wire logic [DATA_W-1:0] cmdData0,   // First write word.
	input  wire logic [DATA_W-1:0] cmdData1,   // Second write word.
	input  wire logic [SEL_W-1:0]  cmdSel0_n,  // Lane enables of first word, low active.
	input  wire logic [SEL_W-1:0]  cmdSel1_n,  // Lane enables of second word, low active.
	input  wire logic              loopBypass, // Run the SRAM with its delay loop off.
	input  wire logic              outOnK,     // Tie output clocks high.
	output logic                   linkReady,  // Lock wait is over.
	output logic                   rspValid,   // Read burst returned, one cycle.
	output logic      [DATA_W-1:0] rspData0,   // First read word.
	output logic      [DATA_W-1:0] rspData1    // Second read word.
);
	logic [CMD_W-1:0]    fifoOut;
	logic                fifoValid;
	logic                fifoPop;
	logic [2:0]          halfCnt;
	logic                halfStep;
	logic                kReg;
	logic                kRiseNow;
	logic                kFallNow;
	ssb_host_t           hostState;
	logic [10:0]         lockCnt;
	logic                launch;
	logic                rdReg_n;
	logic                wrReg_n;
	logic [ADDR_W-1:0]   addrReg;
	logic [DATA_W-1:0]   dataReg;
	logic [SEL_W-1:0]    selReg_n;
	logic [DATA_W-1:0]   data1Hold;
	logic [SEL_W-1:0]    sel1Hold_n;
	logic [DATA_W-1:0]   data0Hold;
	logic [SEL_W-1:0]    sel0Hold_n;
	logic                midStep;
	logic [DATA_W:0]     syncA;
	logic [DATA_W:0]     syncB;
	logic                echoPrev;
	logic                echoEdge;
	logic [MARK_W-1:0]   mark;
	logic [2:0]          pos0;

	ssb_fifo #(
		.WIDTH (CMD_W),
		.DEPTH (FIFO_DEPTH)
	) cmdQueue (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.inValid  (cmdValid),
		.inReady  (cmdReady),
		.inData   ({cmdWrite, cmdAddr, cmdData0, cmdData1, cmdSel0_n, cmdSel1_n}),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoOut)
	);

	// ----------------------------------------
	// Link clock divider and lock wait
	// ----------------------------------------
	assign halfStep = halfCnt == K_HALF_LAST;
	assign kRiseNow = halfStep & ~kReg;
	assign kFallNow = halfStep & kReg;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			halfCnt <= '0;
			kReg <= 1'b0;
		end else begin
			halfCnt <= halfStep ? 3'h0 : halfCnt + 3'h1;
			if (halfStep) begin
				kReg <= ~kReg;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hostState <= HS_WAIT;
			lockCnt <= '0;
		end else begin
			case (hostState)
				HS_WAIT: begin
					if (kRiseNow) begin
						lockCnt <= lockCnt + 11'h001;
						if (lockCnt == LOCK_LAST) begin
							hostState <= HS_RUN; // R03
						end
					end
				end
				HS_RUN: begin
					hostState <= HS_RUN;
				end
				default: begin
					hostState <= HS_WAIT;
				end
			endcase
		end
	end

	assign linkReady = hostState == HS_RUN;

	// ----------------------------------------
	// Command issue
	// ----------------------------------------
	assign fifoPop = linkReady & kFallNow; // R04
	assign launch = fifoPop & fifoValid;
	// Write words change midway between link edges, so each edge sees them settled.
	assign midStep = halfCnt == (K_HALF_LAST >> 1);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdReg_n <= 1'b1;
			wrReg_n <= 1'b1;
			addrReg <= '0;
			dataReg <= '0;
			selReg_n <= '1;
			data0Hold <= '0;
			sel0Hold_n <= '1;
			data1Hold <= '0;
			sel1Hold_n <= '1;
		end else if (kFallNow) begin
			rdReg_n <= ~launch | fifoOut[CMD_W-1]; // R08
			wrReg_n <= ~launch | ~fifoOut[CMD_W-1];
			if (launch) begin
				{addrReg, data0Hold, data1Hold, sel0Hold_n, sel1Hold_n} <= fifoOut[CMD_W-2:0]; // R06
			end
		end else if (midStep) begin
			dataReg <= kReg ? data1Hold : data0Hold; // R07
			selReg_n <= kReg ? sel1Hold_n : sel0Hold_n;
		end
	end

	assign link.k = kReg;
	assign link.kInv = ~kReg;
	assign link.cClk = outOnK | kReg;
	assign link.cClkInv = outOnK | ~kReg;
	assign link.dllOff_n = ~loopBypass; // R01
	assign link.rdReq_n = rdReg_n;
	assign link.wrReq_n = wrReg_n;
	assign link.addr = addrReg;
	assign link.wrData = dataReg;
	assign link.byteWriteSelect_n = selReg_n;

	// ----------------------------------------
	// Read capture on echo edges
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= '0;
			syncB <= '0;
			echoPrev <= 1'b0;
		end else begin
			syncA <= {link.echoStrobe, link.q};
			syncB <= syncA;
			echoPrev <= syncB[DATA_W];
		end
	end

	assign echoEdge = syncB[DATA_W] != echoPrev;
	assign pos0 = (loopBypass ? 3'(LAT_BYP_IDX) : 3'(LAT_NORM_IDX)) + 3'h1 + HOST_SKEW;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mark <= '0;
		end else if (echoEdge) begin
			mark <= {mark[MARK_W-2:0], kRiseNow & ~rdReg_n};
		end else if (kRiseNow && !rdReg_n) begin
			mark[0] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rspValid <= 1'b0;
			rspData0 <= '0;
			rspData1 <= '0;
		end else begin
			rspValid <= echoEdge & mark[pos0 + 3'h1];
			if (echoEdge && mark[pos0]) begin
				rspData0 <= syncB[DATA_W-1:0]; // R09
			end
			if (echoEdge && mark[pos0 + 3'h1]) begin
				rspData1 <= syncB[DATA_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/ssb_chk.sv ====
// Pin-level checker for the burst-of-two SRAM link.
`default_nettype none
module ssb_chk
	import ssb_pkg::*;
(
	input wire logic              clk_sys,           // System clock.
	input wire logic              rst_n,             // Reset, active low.
	input wire logic              k,                 // Link true clock.
	input wire logic              kInv,              // Link inverted clock.
	input wire logic              dllOff_n,          // Loop bypass, low active.
	input wire logic              rdReq_n,           // Read request.
	input wire logic              wrReq_n,           // Write request.
	input wire logic [ADDR_W-1:0] addr,              // Burst address.
	input wire logic [DATA_W-1:0] wrData,            // Write word.
	input wire logic [SEL_W-1:0]  byteWriteSelect_n, // Lane selects.
	input wire logic              qOe_n,             // Read data enable.
	input wire logic              echoStrobe,        // Echo clock.
	input wire logic              echoStrobeInv      // Inverted echo clock.
);
	localparam logic [10:0] LOCK_RISES = 11'h400;
	logic [10:0] kRises;
	logic [5:0]  sinceRd;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			kRises <= 11'h000;
		end else if ($rose(k) && kRises != LOCK_RISES) begin
			kRises <= kRises + 11'h001;
		end
	end

	// Counts cycles since the last read request was presented at a true edge.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sinceRd <= 6'h3f;
		end else if ($rose(k) && !rdReq_n) begin
			sinceRd <= 6'h00;
		end else if (sinceRd != 6'h3f) begin
			sinceRd <= sinceRd + 6'h01;
		end
	end

	a_addr_stable: assert property (k |-> $stable(addr) && $stable(rdReq_n) && $stable(wrReq_n))
		else $error("address or request moved while link clock high");
	a_data_hold: assert property ($rose(k) || $rose(kInv) |-> $stable(wrData)
		&& $stable(byteWriteSelect_n))
		else $error("write word moved across a link clock edge");
	a_lock_idle: assert property (kRises < LOCK_RISES |-> rdReq_n && wrReq_n)
		else $error("request issued during loop lock");
	a_read_normal: assert property ($rose(k) && !rdReq_n && dllOff_n |-> ##[7:13] !qOe_n)
		else $error("normal read data not driven in time");
	a_read_bypass: assert property ($rose(k) && !rdReq_n && !dllOff_n |-> ##[11:18] !qOe_n)
		else $error("bypass read data not driven in time");
	a_drive_hold: assert property (sinceRd == 6'd21 |-> !qOe_n)
		else $error("read data released too early");
	a_hiz_release: assert property (sinceRd == 6'd22 |-> qOe_n)
		else $error("read data not released after last read");
	a_echo_true: assert property ($rose(k) |-> ##[2:3] echoStrobe)
		else $error("echo clock did not follow true edge");
	a_echo_pair: assert property ($rose(kInv) |-> ##3 !echoStrobe && echoStrobeInv)
		else $error("echo clocks did not follow inverted edge");
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench joining controller and SRAM ends of the burst-of-two link.
`default_nettype none
module testbench
	import ssb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                clk_sys, rst_n, rst2_n, k2, k2Run, dllOff2_n, test2Done;
	logic                cmdValid, cmdReady, cmdWrite, loopBypass, outOnK, linkReady, rspValid;
	logic                dllLocked, bypassMode, dllLocked2, bypassMode2;
	logic [ADDR_W-1:0]   cmdAddr;
	logic [DATA_W-1:0]   cmdData0, cmdData1, rspData0, rspData1;
	logic [SEL_W-1:0]    cmdSel0_n, cmdSel1_n;
	logic [DATA_W-1:0]   mem [MEM_WORDS];
	logic [2*DATA_W-1:0] expQ [$];
	int                  err_count, samples_checked;

	ssb_if lnk ();
	ssb_if lnk2 ();
	ssb_device ssb_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk), .dllLocked(dllLocked),
		.bypassMode(bypassMode));
	ssb_host ssb_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData0(cmdData0),
		.cmdData1(cmdData1), .cmdSel0_n(cmdSel0_n), .cmdSel1_n(cmdSel1_n),
		.loopBypass(loopBypass), .outOnK(outOnK), .linkReady(linkReady), .rspValid(rspValid),
		.rspData0(rspData0), .rspData1(rspData1));
	ssb_chk ssb_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .k(lnk.k), .kInv(lnk.kInv),
		.dllOff_n(lnk.dllOff_n), .rdReq_n(lnk.rdReq_n), .wrReq_n(lnk.wrReq_n), .addr(lnk.addr),
		.wrData(lnk.wrData), .byteWriteSelect_n(lnk.byteWriteSelect_n), .qOe_n(lnk.qOe_n),
		.echoStrobe(lnk.echoStrobe), .echoStrobeInv(lnk.echoStrobeInv));
	// Second SRAM end whose link clock the bench stops on purpose.
	ssb_device ssb_device_i2 (.clk_sys(clk_sys), .rst_n(rst2_n), .link(lnk2),
		.dllLocked(dllLocked2), .bypassMode(bypassMode2));
	assign lnk2.k = k2;
	assign lnk2.kInv = ~k2;
	assign lnk2.cClk = k2;
	assign lnk2.cClkInv = ~k2;
	assign lnk2.dllOff_n = dllOff2_n;
	assign lnk2.rdReq_n = 1'b1;
	assign lnk2.wrReq_n = 1'b1;
	assign lnk2.addr = '0;
	assign lnk2.wrData = '0;
	assign lnk2.byteWriteSelect_n = '1;

	initial clk_sys = 1'b0;
	always #50 clk_sys = ~clk_sys;
	initial begin
		k2 = 1'b0;
		#137;
		forever #400 if (k2Run) k2 = ~k2;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] n,
		input logic [SEL_W-1:0] s);
		merge = o;
		for (int i = 0; i < SEL_W; i++) if (!s[i]) merge[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
	endfunction

	// Offers one command at a falling edge and holds it until taken.
	task automatic push(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
		input logic [DATA_W-1:0] d1, input logic [SEL_W-1:0] s0, input logic [SEL_W-1:0] s1);
		int n;
		n = 0;
		cmdValid = 1'b1;
		{cmdWrite, cmdAddr, cmdData0, cmdData1, cmdSel0_n, cmdSel1_n} = {w, a, d0, d1, s0, s1};
		while (cmdReady !== 1'b1 && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 20000) err_count++;
		@(posedge clk_sys);
		if (w) begin
			mem[a] = merge(mem[a], d0, s0);
			mem[a + ADDR_STEP] = merge(mem[a + ADDR_STEP], d1, s1);
		end else begin
			expQ.push_back({mem[a], mem[a + ADDR_STEP]});
		end
		@(negedge clk_sys);
	endtask

	always @(negedge clk_sys) begin
		if (rspValid === 1'b1) begin
			check("rsp_data", {rspData0, rspData1}, expQ.pop_front());
		end
	end

	// ------------------------------------------------------------
	// Main sequence: normal, output clocks tied high, loop bypass
	// ------------------------------------------------------------
	initial begin
		logic [ADDR_W-1:0] a;
		int                n;
		void'($urandom(32'hda69));
		{cmdValid, cmdWrite, cmdAddr, cmdData0, cmdData1, cmdSel0_n, cmdSel1_n} = '0;
		{loopBypass, outOnK, rst2_n, test2Done} = '0;
		err_count = 0;
		samples_checked = 0;
		for (int m = 0; m < 3; m++) begin
			rst_n = 1'b0;
			loopBypass = (m == 2);
			outOnK = (m == 1);
			repeat (4) @(negedge clk_sys);
			rst_n = 1'b1;
			rst2_n = 1'b1;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				push(1'b1, ADDR_W'(2 * i), DATA_W'($urandom), DATA_W'($urandom), '0, '0);
			end
			cmdValid = 1'b0;
			check("fifo_full", 32'(cmdReady), 32'h0);
			check("lock_idle", 32'({linkReady, lnk.rdReq_n, lnk.wrReq_n}), 32'h3);
			n = 0;
			while (linkReady !== 1'b1 && n < 10000) begin
				@(negedge clk_sys);
				n++;
			end
			check("lock_wait", 32'({linkReady, n > 8000}), 32'h3);
			repeat (24) begin
				a = ADDR_W'($urandom_range(62));
				if ($urandom_range(1) == 1) begin
					push(1'b1, a, DATA_W'($urandom), DATA_W'($urandom), SEL_W'($urandom),
						SEL_W'($urandom));
				end else begin
					push(1'b0, a, '0, '0, '1, '1);
				end
			end
			push(1'b1, 8'hff, DATA_W'($urandom), DATA_W'($urandom), 2'h0, 2'h0);
			push(1'b0, 8'hff, '0, '0, '1, '1);
			push(1'b1, 8'h10, DATA_W'($urandom), DATA_W'($urandom), 2'h2, 2'h1);
			push(1'b0, 8'h10, '0, '0, '1, '1);
			cmdValid = 1'b0;
			n = 0;
			while (expQ.size() != 0 && n < 3000) begin
				@(negedge clk_sys);
				n++;
			end
			repeat (40) @(negedge clk_sys);
			check("drain", 32'(expQ.size()), 32'h0);
			check("mode", 32'({bypassMode, dllLocked, lnk.dllOff_n, lnk.qOe_n}),
				(m == 2) ? 32'h9 : 32'h7);
			if (m == 1) begin
				check("out_clk_tie", 32'({lnk.cClk, lnk.cClkInv}), 32'h3);
			end
		end
		n = 0;
		while (test2Done !== 1'b1 && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		check("second_end", 32'(test2Done), 32'h1);
		complete_run();
	end

	// Lock, stopped clock and bypass on the second SRAM end.
	initial begin
		k2Run = 1'b0;
		dllOff2_n = 1'b1;
		wait (rst2_n === 1'b1);
		k2Run = 1'b1;
		repeat (1000) @(posedge k2);
		@(negedge clk_sys);
		check("lock2_early", 32'(dllLocked2), 32'h0);
		repeat (40) @(posedge k2);
		@(negedge clk_sys);
		check("lock2", 32'(dllLocked2), 32'h1);
		k2Run = 1'b0;
		repeat (12) @(negedge clk_sys);
		check("static_reset", 32'(dllLocked2), 32'h0);
		dllOff2_n = 1'b0;
		repeat (12) @(negedge clk_sys);
		check("bypass2", 32'(bypassMode2), 32'h1);
		test2Done = 1'b1;
	end

	initial begin
		repeat (60000) @(posedge clk_sys);
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
